// *** core/flr_params.svh ***
// Constants of the switchable port load relay control: counts, widths, encodings.
// Assumes it is included by bare name from the package and the design modules.
`ifndef FLR_PARAMS_SVH
`define FLR_PARAMS_SVH

`define FLR_NC 3
`define FLR_VW 16
`define FLR_SOCW 8
`define FLR_TW 17
`define FLR_CW 16
`define FLR_NPWR 16
`define FLR_PSW 4
`define FLR_NPHASE 7
`define FLR_NCMD 7
`define FLR_CMDW 3
`define FLR_WDW 3
`define FLR_CNT_ZERO 16'h0000
`define FLR_CNT_ONE 16'h0001
`define FLR_CNT_MAX 16'hffff
`define FLR_MAX_OFF 16'hffff
`define FLR_WD_TOP 3'h6
`define FLR_CMD_NONE 3'h0
`define FLR_CMD_ONE 3'h1
`define FLR_ALM_ERR 2'h1
`define FLR_ALM_WRN 2'h2

`endif

// *** core/flr_pkg.sv ***
// Types shared by the load relay control modules.
// Assumes the constants header sits beside it on the include path.
`include "flr_params.svh"

package flr_pkg;

	typedef enum logic [1:0] {
		FLR_MODE_OFF,
		FLR_MODE_ON,
		FLR_MODE_AUTO
	} flr_mode_t;

	typedef enum logic [3:0] {
		FLR_COND_BATT_V,
		FLR_COND_SOC,
		FLR_COND_TEMP,
		FLR_COND_CHG_PHASE,
		FLR_COND_AC_POWER,
		FLR_COND_GRID_EXCESS,
		FLR_COND_SOLAR_EXCESS,
		FLR_COND_SCHEDULE,
		FLR_COND_ON_SOURCE,
		FLR_COND_OFF_SOURCE,
		FLR_COND_CMD_INPUT,
		FLR_COND_ALARM
	} flr_cond_t;

	typedef enum logic [2:0] {
		FLR_PH_NONE,
		FLR_PH_BULK,
		FLR_PH_RED_FLOAT,
		FLR_PH_FLOAT,
		FLR_PH_PER_ABS,
		FLR_PH_ABS,
		FLR_PH_EQUAL
	} flr_phase_t;

endpackage

// *** core/flr_hyst.sv ***
// Two-threshold hysteresis on one signed measurement, evaluated on the tick.
// Assumes a single clock, tick and enable shared with the instantiating block.
`timescale 1ns/1ps
`include "flr_params.svh"

module flr_hyst import flr_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic tick,
	input wire logic clr,
	input wire logic [`FLR_VW-1:0] value,
	input wire logic [`FLR_VW-1:0] act_th,
	input wire logic [`FLR_VW-1:0] deact_th,
	output logic state
);
	logic inv;
	logic hit_set;
	logic hit_clr;

	// Activation above deactivation turns the sense round.
	assign inv = $signed(act_th) > $signed(deact_th);
	assign hit_set = inv ? ($signed(value) >= $signed(act_th)) : ($signed(value) <= $signed(act_th));
	assign hit_clr = inv ? ($signed(value) <= $signed(deact_th)) : ($signed(value) >= $signed(deact_th));

	// Set is checked first so equal thresholds never leave the output dead.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= 1'b0;
		end else if (ce) begin
			if (clr) begin
				state <= 1'b0;
			end else if (tick) begin
				if (hit_set) begin
					state <= 1'b1;
				end else if (hit_clr) begin
					state <= 1'b0;
				end
			end
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_hyst_set_now: assert property (ce && tick && !clr && hit_set |=> state)
		else $error("Hysteresis did not set at activation level.");
	a_hyst_hold_mid: assert property (ce && tick && !clr && !hit_set && !hit_clr |=> state == $past(state))
		else $error("Hysteresis changed between thresholds.");
	a_hyst_inv_clr: assert property (ce && tick && !clr && inv && !hit_set && hit_clr |=> !state)
		else $error("Inverted hysteresis did not clear.");
endmodule

// *** core/flr_top.sv ***
// Load relay control of the switchable port: three phase contacts and the neutral.
// Assumes measurements, status flags, time of day and a one-second tick come in synchronous to clk.
// Function
// - Three phase contacts, each with its own mode and condition settings.
// - Neutral contact closes while any phase contact is closed.
// - Manual off keeps the contact open; open also under reset.
// - Manual on keeps the contact closed whatever the conditions when the port is a load; a source port stays open.
// - In automatic mode one selected condition drives each contact.
// - Battery voltage condition sets and clears on two thresholds, holds between.
// - Charge level condition uses the same two-threshold hysteresis.
// - Battery temperature condition uses two-threshold hysteresis.
// - Charge phase condition is true when the phase is in the selected set.
// - AC power condition picks one of sixteen measurements with hysteresis.
// - Grid export condition applies hysteresis to exported power.
// - Solar excess condition is true while any solar converter is limited.
// - Schedule condition is true only inside the daily time window.
// - On-source condition is true while an external source is connected.
// - Off-source condition is true while running without an external source.
// - Command input condition follows the selected command input.
// - Alarm condition is true while a selected alarm is present.
// - Source or load use of the port is fixed at configuration.
// - Most conditions may pass through an optional temporal restriction stage.
// - Activation above deactivation threshold inverts the hysteresis sense.
// - Output changes only after the condition held for the minimum delay.
// - After maximum on time the output locks off until condition clears.
// - Allowed weekdays are a seven-bit mask, Monday on top, Sunday lowest.
`timescale 1ns/1ps
`include "flr_params.svh"

module flr_top import flr_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic tick,
	input wire logic port_is_load,
	input wire flr_mode_t [`FLR_NC-1:0] mode,
	input wire flr_cond_t [`FLR_NC-1:0] cond,
	input wire logic [`FLR_NC-1:0][`FLR_VW-1:0] act_th,
	input wire logic [`FLR_NC-1:0][`FLR_VW-1:0] deact_th,
	input wire logic [`FLR_NC-1:0][`FLR_PSW-1:0] power_sel,
	input wire logic [`FLR_NC-1:0][`FLR_NPHASE-1:0] phase_mask,
	input wire logic [`FLR_NC-1:0][`FLR_CMDW-1:0] cmd_index,
	input wire logic [`FLR_NC-1:0][1:0] alarm_sel,
	input wire logic [`FLR_NC-1:0][`FLR_TW-1:0] sched_start,
	input wire logic [`FLR_NC-1:0][`FLR_TW-1:0] sched_end,
	input wire logic [`FLR_NC-1:0] temporal_en,
	input wire logic [`FLR_NC-1:0][`FLR_CW-1:0] act_min_delay,
	input wire logic [`FLR_NC-1:0][`FLR_CW-1:0] deact_min_delay,
	input wire logic [`FLR_NC-1:0][`FLR_CW-1:0] act_min_time,
	input wire logic [`FLR_NC-1:0][`FLR_CW-1:0] deact_min_time,
	input wire logic [`FLR_NC-1:0][`FLR_CW-1:0] act_max_time,
	input wire logic [`FLR_NC-1:0][`FLR_TW-1:0] hour_allow1,
	input wire logic [`FLR_NC-1:0][`FLR_TW-1:0] hour_allow2,
	input wire logic [`FLR_NC-1:0][`FLR_NPHASE-1:0] weekday_allowed,
	input wire logic [`FLR_VW-1:0] batt_voltage,
	input wire logic [`FLR_SOCW-1:0] batt_soc,
	input wire logic [`FLR_VW-1:0] batt_temp,
	input wire logic [`FLR_NPWR-1:0][`FLR_VW-1:0] ac_power,
	input wire logic [`FLR_VW-1:0] grid_export_power,
	input wire flr_phase_t charge_phase,
	input wire logic solar_limited,
	input wire logic on_source,
	input wire logic inverter_on,
	input wire logic [`FLR_NCMD-1:0] cmd_inputs,
	input wire logic alarm_error,
	input wire logic alarm_warning,
	input wire logic [`FLR_TW-1:0] time_of_day,
	input wire logic [`FLR_WDW-1:0] weekday,
	output logic [`FLR_NC-1:0] phase_contact,
	output logic neutral_contact,
	output logic port_load_mode,
	output logic [`FLR_NC-1:0] contact_locked
);

	function automatic logic in_window(
		input logic [`FLR_TW-1:0] t,
		input logic [`FLR_TW-1:0] a,
		input logic [`FLR_TW-1:0] b
	);
		logic r;
		r = 1'b1;
		if (a < b) begin
			r = (t >= a) && (t < b);
		end else if (a > b) begin
			r = (t >= a) || (t < b);
		end
		return r;
	endfunction

	function automatic logic [`FLR_CW-1:0] sat_inc(input logic [`FLR_CW-1:0] c);
		logic [`FLR_CW-1:0] r;
		r = c;
		if (c != `FLR_CNT_MAX) begin
			r = c + `FLR_CNT_ONE;
		end
		return r;
	endfunction

	logic cfg_done;
	logic [`FLR_NC-1:0][`FLR_VW-1:0] hval;
	logic [`FLR_NC-1:0] hclr;
	logic [`FLR_NC-1:0] hstate;
	logic [`FLR_NC-1:0] raw;
	logic [`FLR_NC-1:0] auto_on;
	logic [`FLR_NC-1:0] bypass;
	logic [`FLR_NC-1:0] allowed;
	logic [`FLR_NC-1:0] eff;
	logic [`FLR_NC-1:0] tout;
	logic [`FLR_NC-1:0] locked;
	logic [`FLR_NC-1:0][`FLR_CW-1:0] dly;
	logic [`FLR_NC-1:0][`FLR_CW-1:0] tim;
	logic [`FLR_NC-1:0] next_contact;

	// The port role is caught once after reset and never follows the pin again,
	// so a live change cannot turn a source input into a switched load.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_done <= 1'b0;
			port_load_mode <= 1'b0;
		end else if (ce && !cfg_done) begin
			cfg_done <= 1'b1;
			port_load_mode <= port_is_load;
		end
	end

	genvar i;
	generate
		for (i = 0; i < `FLR_NC; i++) begin : g_contact
			assign auto_on[i] = port_load_mode && (mode[i] == FLR_MODE_AUTO);
			assign hclr[i] = !auto_on[i];
			assign bypass[i] = !temporal_en[i] || (cond[i] == FLR_COND_SCHEDULE);
			assign allowed[i] = in_window(time_of_day, hour_allow1[i], hour_allow2[i])
				&& weekday_allowed[i][`FLR_WD_TOP - weekday];
			assign eff[i] = raw[i] && allowed[i] && !locked[i];

			always_comb begin
				case (cond[i])
					FLR_COND_SOC: hval[i] = {{(`FLR_VW - `FLR_SOCW){1'b0}}, batt_soc};
					FLR_COND_TEMP: hval[i] = batt_temp;
					FLR_COND_AC_POWER: hval[i] = ac_power[power_sel[i]];
					FLR_COND_GRID_EXCESS: hval[i] = grid_export_power;
					default: hval[i] = batt_voltage;
				endcase
			end

			flr_hyst u_hyst (
				.clk(clk),
				.rst_n(rst_n),
				.ce(ce),
				.tick(tick),
				.clr(hclr[i]),
				.value(hval[i]),
				.act_th(act_th[i]),
				.deact_th(deact_th[i]),
				.state(hstate[i])
			);

			// Exactly one condition is chosen per contact by the selector.
			always_comb begin
				case (cond[i])
					FLR_COND_BATT_V,
					FLR_COND_SOC,
					FLR_COND_TEMP,
					FLR_COND_AC_POWER,
					FLR_COND_GRID_EXCESS: raw[i] = hstate[i];
					FLR_COND_CHG_PHASE: raw[i] = phase_mask[i][charge_phase];
					FLR_COND_SOLAR_EXCESS: raw[i] = solar_limited;
					FLR_COND_SCHEDULE: raw[i] = in_window(time_of_day, sched_start[i], sched_end[i]);
					FLR_COND_ON_SOURCE: raw[i] = on_source;
					FLR_COND_OFF_SOURCE: raw[i] = inverter_on && !on_source;
					FLR_COND_CMD_INPUT: raw[i] = (cmd_index[i] != `FLR_CMD_NONE)
						&& cmd_inputs[cmd_index[i] - `FLR_CMD_ONE];
					FLR_COND_ALARM: begin
						case (alarm_sel[i])
							`FLR_ALM_ERR: raw[i] = alarm_error;
							`FLR_ALM_WRN: raw[i] = alarm_warning;
							default: raw[i] = alarm_error || alarm_warning;
						endcase
					end
					default: raw[i] = 1'b0;
				endcase
			end

			// Temporal stage. Counters run in ticks and saturate rather than wrap,
			// so a very long wait never looks like a short one.
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					tout[i] <= 1'b0;
					locked[i] <= 1'b0;
					dly[i] <= `FLR_CNT_ZERO;
					tim[i] <= `FLR_CNT_ZERO;
				end else if (ce) begin
					if (!auto_on[i]) begin
						tout[i] <= 1'b0;
						locked[i] <= 1'b0;
						dly[i] <= `FLR_CNT_ZERO;
						tim[i] <= `FLR_CNT_ZERO;
					end else if (tick) begin
						if (!raw[i]) begin
							locked[i] <= 1'b0;
						end
						if (bypass[i]) begin
							tout[i] <= raw[i];
							locked[i] <= 1'b0;
							dly[i] <= `FLR_CNT_ZERO;
							tim[i] <= `FLR_CNT_ZERO;
						end else if (tout[i]) begin
							tim[i] <= sat_inc(tim[i]);
							if (act_max_time[i] != `FLR_MAX_OFF && tim[i] >= act_max_time[i]) begin
								tout[i] <= 1'b0;
								locked[i] <= raw[i];
								dly[i] <= `FLR_CNT_ZERO;
								tim[i] <= `FLR_CNT_ZERO;
							end else if (!eff[i]) begin
								if (dly[i] >= deact_min_delay[i] && tim[i] >= act_min_time[i]) begin
									tout[i] <= 1'b0;
									dly[i] <= `FLR_CNT_ZERO;
									tim[i] <= `FLR_CNT_ZERO;
								end else begin
									dly[i] <= sat_inc(dly[i]);
								end
							end else begin
								dly[i] <= `FLR_CNT_ZERO;
							end
						end else begin
							tim[i] <= sat_inc(tim[i]);
							if (eff[i]) begin
								if (dly[i] >= act_min_delay[i] && tim[i] >= deact_min_time[i]) begin
									tout[i] <= 1'b1;
									dly[i] <= `FLR_CNT_ZERO;
									tim[i] <= `FLR_CNT_ZERO;
								end else begin
									dly[i] <= sat_inc(dly[i]);
								end
							end else begin
								dly[i] <= `FLR_CNT_ZERO;
							end
						end
					end
				end
			end

			always_comb begin
				case (mode[i])
					FLR_MODE_ON: next_contact[i] = port_load_mode;
					FLR_MODE_AUTO: next_contact[i] = port_load_mode && tout[i];
					default: next_contact[i] = 1'b0;
				endcase
			end
		end
	endgenerate

	// Contacts and neutral come from the same next value, so the neutral never
	// lags or leads the phases by a cycle.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_contact <= '0;
			neutral_contact <= 1'b0;
			contact_locked <= '0;
		end else if (ce) begin
			phase_contact <= next_contact;
			neutral_contact <= |next_contact;
			contact_locked <= locked;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_neutral_follows: assert property (neutral_contact == |phase_contact)
		else $error("Neutral contact disagrees with phase contacts.");
	a_role_fixed: assert property (cfg_done |=> $stable(port_load_mode))
		else $error("Port role changed during operation.");
	a_source_opens: assert property (ce && !port_load_mode |=> phase_contact == '0)
		else $error("Contact closed while port is a source.");
	a_freeze_hold: assert property (!ce |=> $stable(phase_contact) && $stable(tout))
		else $error("State moved while clock enable was low.");

	generate
		for (i = 0; i < `FLR_NC; i++) begin : g_chk
			sequence s_off_seen;
				ce && mode[i] == FLR_MODE_OFF;
			endsequence
			sequence s_on_seen;
				ce && mode[i] == FLR_MODE_ON && port_load_mode;
			endsequence
			sequence s_timer_tick;
				ce && tick && auto_on[i] && !bypass[i];
			endsequence

			a_manual_off: assert property (s_off_seen |=> !phase_contact[i] ##1 !contact_locked[i])
				else $error("Contact closed in manual off.");
			a_manual_on: assert property (s_on_seen |=> phase_contact[i])
				else $error("Contact open in manual on.");
			a_act_delay: assert property ((s_timer_tick and (!tout[i] && eff[i] && dly[i] < act_min_delay[i]))
				|=> !tout[i])
				else $error("Output activated before minimum delay.");
			a_lock_keep: assert property ((s_timer_tick and (locked[i] && raw[i])) |=> locked[i] && !tout[i])
				else $error("Lock released while condition present.");
			a_lock_set: assert property ((s_timer_tick and (tout[i] && raw[i]
				&& act_max_time[i] != `FLR_MAX_OFF && tim[i] >= act_max_time[i])) |=> locked[i] && !tout[i] ##1 ce
				|-> !phase_contact[i])
				else $error("Maximum on time did not lock the output.");
			a_tick_only: assert property (ce && !tick && auto_on[i] |=> $stable(tout[i]))
				else $error("Temporal output moved without a tick.");
		end
	endgenerate
endmodule

// *** verif/flr_sys_model.sv ***
// Measurement, status and alarm sources beside the load relay control, with the evaluation tick.
// Assumes the bench sets values through these tasks just after a rising clock edge.
`timescale 1ns/1ps
`include "flr_params.svh"

module flr_sys_model import flr_pkg::*; (
	input wire logic clk,
	output logic tick,
	output logic [`FLR_VW-1:0] batt_voltage,
	output logic [`FLR_SOCW-1:0] batt_soc,
	output logic [`FLR_VW-1:0] batt_temp,
	output logic [`FLR_NPWR-1:0][`FLR_VW-1:0] ac_power,
	output logic [`FLR_VW-1:0] grid_export_power,
	output flr_phase_t charge_phase,
	output logic solar_limited,
	output logic on_source,
	output logic inverter_on,
	output logic [`FLR_NCMD-1:0] cmd_inputs,
	output logic alarm_error,
	output logic alarm_warning,
	output logic [`FLR_TW-1:0] time_of_day,
	output logic [`FLR_WDW-1:0] weekday
);
	logic [1:0] div = 2'h0;
	// A tick every fourth cycle keeps all hysteresis and delay cases short.
	always @(posedge clk) begin
		div <= div + 2'h1;
	end
	assign tick = (div == 2'h3);
	initial begin
		batt_voltage = '0;
		batt_soc = '0;
		batt_temp = '0;
		ac_power = '0;
		grid_export_power = '0;
		charge_phase = FLR_PH_NONE;
		solar_limited = 1'b0;
		on_source = 1'b0;
		inverter_on = 1'b0;
		cmd_inputs = '0;
		alarm_error = 1'b0;
		alarm_warning = 1'b0;
		time_of_day = '0;
		weekday = 3'h0;
	end
	// Unselected power entries carry the inverse, so a wrong selection shows.
	task automatic set_value(input flr_cond_t c, input logic [`FLR_VW-1:0] v);
		case (c)
			FLR_COND_BATT_V: batt_voltage = v;
			FLR_COND_SOC: batt_soc = v[`FLR_SOCW-1:0];
			FLR_COND_TEMP: batt_temp = v;
			FLR_COND_GRID_EXCESS: grid_export_power = v;
			default: for (int k = 0; k < `FLR_NPWR; k++) ac_power[k] = (k == 8) ? v : ~v;
		endcase
	endtask
	task automatic set_flag(input flr_cond_t c, input logic v);
		case (c)
			FLR_COND_CHG_PHASE: charge_phase = v ? FLR_PH_EQUAL : FLR_PH_BULK;
			FLR_COND_SOLAR_EXCESS: solar_limited = v;
			FLR_COND_ON_SOURCE: on_source = v;
			FLR_COND_OFF_SOURCE: inverter_on = v;
			FLR_COND_CMD_INPUT: cmd_inputs = v ? 7'h04 : 7'h7b;
			default: begin
				alarm_warning = v;
				alarm_error = !v;
			end
		endcase
	endtask
	task automatic set_clock(input logic [`FLR_TW-1:0] t, input logic [`FLR_WDW-1:0] d);
		time_of_day = t;
		weekday = d;
	endtask
endmodule

// *** verif/test_flex_port_load_relay_control.sv ***
// Self-checking bench of the load relay control: manual modes, every condition, temporal stage, role.
// Assumes the system source model in the same folder and the design package compiled first.
`timescale 1ns/1ps
`include "flr_params.svh"

module test_flex_port_load_relay_control import flr_pkg::*;;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic port_is_load = 1'b1;
	flr_mode_t [`FLR_NC-1:0] mode;
	flr_cond_t [`FLR_NC-1:0] cond;
	logic [`FLR_NC-1:0][`FLR_VW-1:0] act_th = '0;
	logic [`FLR_NC-1:0][`FLR_VW-1:0] deact_th = '0;
	logic [`FLR_NC-1:0][`FLR_PSW-1:0] power_sel = {3{4'h8}};
	logic [`FLR_NC-1:0][`FLR_NPHASE-1:0] phase_mask = {3{7'h40}};
	logic [`FLR_NC-1:0][`FLR_CMDW-1:0] cmd_index = {3{3'h3}};
	logic [`FLR_NC-1:0][1:0] alarm_sel = {3{2'h2}};
	logic [`FLR_NC-1:0][`FLR_TW-1:0] sched_start = {3{17'h00064}};
	logic [`FLR_NC-1:0][`FLR_TW-1:0] sched_end = {3{17'h000c8}};
	logic [`FLR_NC-1:0] temporal_en = '0;
	logic [`FLR_NC-1:0][`FLR_CW-1:0] act_min_delay = '0;
	logic [`FLR_NC-1:0][`FLR_CW-1:0] deact_min_delay = '0;
	logic [`FLR_NC-1:0][`FLR_CW-1:0] act_min_time = '0;
	logic [`FLR_NC-1:0][`FLR_CW-1:0] deact_min_time = '0;
	logic [`FLR_NC-1:0][`FLR_CW-1:0] act_max_time = '1;
	logic [`FLR_NC-1:0][`FLR_TW-1:0] hour_allow1 = '0;
	logic [`FLR_NC-1:0][`FLR_TW-1:0] hour_allow2 = '0;
	logic [`FLR_NC-1:0][`FLR_NPHASE-1:0] weekday_allowed = '1;
	logic tick, solar_limited, on_source, inverter_on, alarm_error, alarm_warning, neutral_contact, port_load_mode;
	logic [`FLR_VW-1:0] batt_voltage, batt_temp, grid_export_power;
	logic [`FLR_SOCW-1:0] batt_soc;
	logic [`FLR_NPWR-1:0][`FLR_VW-1:0] ac_power;
	flr_phase_t charge_phase;
	logic [`FLR_NCMD-1:0] cmd_inputs;
	logic [`FLR_TW-1:0] time_of_day;
	logic [`FLR_WDW-1:0] weekday;
	logic [`FLR_NC-1:0] phase_contact, contact_locked;
	int errors = 0;
	int checks_done = 0;

	flr_sys_model flr_sys_model_inst (.clk(clk), .tick(tick), .batt_voltage(batt_voltage), .batt_soc(batt_soc),
		.batt_temp(batt_temp), .ac_power(ac_power), .grid_export_power(grid_export_power),
		.charge_phase(charge_phase), .solar_limited(solar_limited), .on_source(on_source),
		.inverter_on(inverter_on), .cmd_inputs(cmd_inputs), .alarm_error(alarm_error),
		.alarm_warning(alarm_warning), .time_of_day(time_of_day), .weekday(weekday));

	flr_top flr_top_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .tick(tick), .port_is_load(port_is_load),
		.mode(mode), .cond(cond), .act_th(act_th), .deact_th(deact_th), .power_sel(power_sel),
		.phase_mask(phase_mask), .cmd_index(cmd_index), .alarm_sel(alarm_sel), .sched_start(sched_start),
		.sched_end(sched_end), .temporal_en(temporal_en), .act_min_delay(act_min_delay),
		.deact_min_delay(deact_min_delay), .act_min_time(act_min_time), .deact_min_time(deact_min_time),
		.act_max_time(act_max_time), .hour_allow1(hour_allow1), .hour_allow2(hour_allow2),
		.weekday_allowed(weekday_allowed), .batt_voltage(batt_voltage), .batt_soc(batt_soc),
		.batt_temp(batt_temp), .ac_power(ac_power), .grid_export_power(grid_export_power),
		.charge_phase(charge_phase), .solar_limited(solar_limited), .on_source(on_source),
		.inverter_on(inverter_on), .cmd_inputs(cmd_inputs), .alarm_error(alarm_error),
		.alarm_warning(alarm_warning), .time_of_day(time_of_day), .weekday(weekday),
		.phase_contact(phase_contact), .neutral_contact(neutral_contact), .port_load_mode(port_load_mode),
		.contact_locked(contact_locked));

	initial begin
		forever #25 clk = ~clk;
	end

	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic check_bit(input string what, input logic exp, input logic got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic check_vec(input string what, input logic [2:0] exp, input logic [2:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask

	// Inputs move five nanoseconds after an edge, so ticks are sampled one nanosecond after it.
	task automatic wait_ticks(input int n);
		int seen;
		int guard;
		seen = 0;
		guard = 0;
		while (seen < n) begin
			@(posedge clk);
			#1;
			guard++;
			if (tick === 1'b1) seen++;
			if (guard > 20 * n) begin
				errors++;
				$display("[ERR] tick wait expected %0d seen %0d", n, seen);
				wrap_up();
			end
		end
		cyc(2);
	endtask

	task automatic do_reset(input logic load);
		rst_n = 1'b0;
		port_is_load = load;
		cyc(20);
		check_vec("contacts in reset", 3'h0, phase_contact);
		check_vec("lock in reset", 3'h0, contact_locked);
		check_bit("neutral in reset", 1'b0, neutral_contact);
		rst_n = 1'b1;
		cyc(2);
	endtask

	task automatic manual_case();
		ce = 1'b0;
		mode[1] = FLR_MODE_ON;
		cyc(3);
		check_vec("frozen", 3'h0, phase_contact);
		ce = 1'b1;
		cyc(3);
		check_vec("one on", 3'h2, phase_contact);
		check_bit("neutral on", 1'b1, neutral_contact);
		mode[2] = FLR_MODE_ON;
		cyc(3);
		check_vec("two on", 3'h6, phase_contact);
		mode[1] = FLR_MODE_OFF;
		mode[2] = FLR_MODE_OFF;
		cyc(3);
		check_vec("all off", 3'h0, phase_contact);
		check_bit("neutral off", 1'b0, neutral_contact);
		$display("Test manual_case done");
	endtask

	task automatic hyst_case(input flr_cond_t c, input logic [15:0] a, d, vs, vm, vc);
		cond[0] = c;
		act_th[0] = a;
		deact_th[0] = d;
		flr_sys_model_inst.set_value(c, vm);
		mode[0] = FLR_MODE_AUTO;
		wait_ticks(3);
		check_vec("hold cleared", 3'h0, phase_contact);
		flr_sys_model_inst.set_value(c, vs);
		wait_ticks(3);
		check_vec("set", 3'h1, phase_contact);
		check_bit("neutral", 1'b1, neutral_contact);
		flr_sys_model_inst.set_value(c, vm);
		wait_ticks(3);
		check_vec("hold set", 3'h1, phase_contact);
		flr_sys_model_inst.set_value(c, vc);
		wait_ticks(3);
		check_vec("clear", 3'h0, phase_contact);
		mode[0] = FLR_MODE_OFF;
		cyc(2);
		$display("Test hyst_case %0d done", c);
	endtask

	task automatic bool_case(input flr_cond_t c);
		cond[0] = c;
		mode[0] = FLR_MODE_AUTO;
		wait_ticks(3);
		check_vec("idle", 3'h0, phase_contact);
		flr_sys_model_inst.set_flag(c, 1'b1);
		wait_ticks(3);
		check_vec("true", 3'h1, phase_contact);
		flr_sys_model_inst.set_flag(c, 1'b0);
		wait_ticks(3);
		check_vec("false", 3'h0, phase_contact);
		if (c == FLR_COND_ALARM) begin
			alarm_sel[0] = 2'h1;
			wait_ticks(3);
			check_vec("error alarm", 3'h1, phase_contact);
			alarm_sel[0] = 2'h0;
			flr_sys_model_inst.set_flag(c, 1'b1);
			wait_ticks(3);
			check_vec("any alarm", 3'h1, phase_contact);
		end
		if (c == FLR_COND_CMD_INPUT) begin
			cmd_index[0] = 3'h1;
			wait_ticks(3);
			check_vec("first input", 3'h1, phase_contact);
			cmd_index[0] = 3'h0;
			wait_ticks(3);
			check_vec("no input", 3'h0, phase_contact);
		end
		mode[0] = FLR_MODE_OFF;
		cyc(2);
		$display("Test bool_case %0d done", c);
	endtask

	task automatic sched_case();
		cond[0] = FLR_COND_SCHEDULE;
		temporal_en[0] = 1'b1;
		act_min_delay[0] = 16'h0010;
		flr_sys_model_inst.set_clock(17'h00096, 3'h0);
		mode[0] = FLR_MODE_AUTO;
		wait_ticks(3);
		check_vec("inside window", 3'h1, phase_contact);
		flr_sys_model_inst.set_clock(17'h000fa, 3'h0);
		wait_ticks(3);
		check_vec("outside window", 3'h0, phase_contact);
		mode[0] = FLR_MODE_OFF;
		act_min_delay[0] = 16'h0003;
		deact_min_delay[0] = 16'h0003;
		cyc(2);
		$display("Test sched_case done");
	endtask

	task automatic temporal_case();
		cond[0] = FLR_COND_SOLAR_EXCESS;
		mode[0] = FLR_MODE_AUTO;
		flr_sys_model_inst.set_flag(FLR_COND_SOLAR_EXCESS, 1'b1);
		wait_ticks(1);
		check_vec("before delay", 3'h0, phase_contact);
		wait_ticks(6);
		check_vec("after delay", 3'h1, phase_contact);
		flr_sys_model_inst.set_flag(FLR_COND_SOLAR_EXCESS, 1'b0);
		wait_ticks(1);
		check_vec("before off delay", 3'h1, phase_contact);
		wait_ticks(6);
		check_vec("after off delay", 3'h0, phase_contact);
		act_min_delay[0] = '0;
		deact_min_delay[0] = '0;
		act_max_time[0] = 16'h0004;
		flr_sys_model_inst.set_flag(FLR_COND_SOLAR_EXCESS, 1'b1);
		wait_ticks(12);
		check_vec("locked off", 3'h0, phase_contact);
		check_vec("lock flag", 3'h1, contact_locked);
		flr_sys_model_inst.set_flag(FLR_COND_SOLAR_EXCESS, 1'b0);
		wait_ticks(3);
		check_vec("lock released", 3'h0, contact_locked);
		act_max_time[0] = '1;
		weekday_allowed[0] = 7'h3f;
		flr_sys_model_inst.set_flag(FLR_COND_SOLAR_EXCESS, 1'b1);
		wait_ticks(4);
		check_vec("day barred", 3'h0, phase_contact);
		weekday_allowed[0] = 7'h40;
		wait_ticks(4);
		check_vec("day allowed", 3'h1, phase_contact);
		mode[0] = FLR_MODE_OFF;
		cyc(2);
		$display("Test temporal_case done");
	endtask

	task automatic role_case();
		do_reset(1'b0);
		mode[1] = FLR_MODE_ON;
		cyc(4);
		check_bit("source role", 1'b0, port_load_mode);
		check_vec("source contacts", 3'h0, phase_contact);
		port_is_load = 1'b1;
		cyc(4);
		check_vec("role fixed", 3'h0, phase_contact);
		do_reset(1'b1);
		cyc(4);
		check_bit("load role", 1'b1, port_load_mode);
		check_vec("load contacts", 3'h2, phase_contact);
		$display("Test role_case done");
	endtask

	initial begin
		for (int i = 0; i < `FLR_NC; i++) begin
			mode[i] = FLR_MODE_OFF;
			cond[i] = FLR_COND_SOLAR_EXCESS;
		end
		do_reset(1'b1);
		check_bit("initial role", 1'b1, port_load_mode);
		manual_case();
		hyst_case(FLR_COND_BATT_V, 16'h0064, 16'h00c8, 16'h0032, 16'h0096, 16'h00fa);
		hyst_case(FLR_COND_SOC, 16'h0050, 16'h0014, 16'h005a, 16'h0032, 16'h000a);
		hyst_case(FLR_COND_TEMP, 16'h00c8, 16'hff9c, 16'h00fa, 16'h0000, 16'hff38);
		hyst_case(FLR_COND_AC_POWER, 16'h0064, 16'h00c8, 16'h0032, 16'h0096, 16'h00fa);
		hyst_case(FLR_COND_GRID_EXCESS, 16'h01f4, 16'h0064, 16'h0258, 16'h012c, 16'h0032);
		bool_case(FLR_COND_CHG_PHASE);
		bool_case(FLR_COND_SOLAR_EXCESS);
		bool_case(FLR_COND_ON_SOURCE);
		bool_case(FLR_COND_OFF_SOURCE);
		bool_case(FLR_COND_CMD_INPUT);
		bool_case(FLR_COND_ALARM);
		sched_case();
		temporal_case();
		role_case();
		wrap_up();
	end
endmodule
